// *** design/vsw_pkg.sv ***
package vsw_pkg;

    // ==========================================================
    // sub-addresses and reset values
    localparam logic [7:0] SUB_SINK1    = 8'h01;
    localparam logic [7:0] SUB_SINK2    = 8'h02;
    localparam logic [7:0] SUB_STATUS   = 8'h03;
    localparam logic [7:0] SUB_RESET    = 8'h01;
    localparam logic [7:0] REG_RESET    = 8'h03;
    localparam logic [7:0] RD_UNMAPPED  = 8'h00;

    // ==========================================================
    // slave address
    localparam logic [4:0] ADDR_PREFIX  = 5'h0B;

    // ==========================================================
    // sink control fields
    localparam int         SINK_DEEMPH_BIT = 4;
    localparam int         SINK_DDC_BIT    = 3;
    localparam int         SINK_OE_BIT     = 2;
    localparam int         SINK_SEL_LSB    = 0;
    localparam logic [7:0] SINK_WR_MASK    = 8'h1F;

    // ==========================================================
    // status register fields
    localparam int         STAT_GATE_BIT   = 4;
    localparam int         STAT_MAIN_BIT   = 5;
    localparam logic [7:0] STAT_WR_MASK    = 8'h30;
    localparam logic [7:0] STAT_RESET      = REG_RESET & STAT_WR_MASK;

    localparam int         NUM_SOURCES     = 4;

    // ==========================================================
    // link state machine
    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_ADDR     = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_SUB      = 9'h008,
        ST_SUB_ACK  = 9'h010,
        ST_DATA     = 9'h020,
        ST_DATA_ACK = 9'h040,
        ST_READ     = 9'h080,
        ST_READ_ACK = 9'h100
    } vsw_state_t;

endpackage : vsw_pkg

// *** design/vsw_sink_if.sv ***
`timescale 1ns/1ps
interface vsw_sink_if;
    logic       wr_en;
    logic [7:0] wr_data;
    logic [3:0] power;
    logic       gate;
    logic [7:0] ctrl;
    logic       de_emph;
    logic       ddc_en;
    logic       tmds_en;
    logic [1:0] sel;

    modport host (output wr_en, wr_data, power, gate, input ctrl, de_emph, ddc_en, tmds_en, sel);
    modport chan (input wr_en, wr_data, power, gate, output ctrl, de_emph, ddc_en, tmds_en, sel);
endinterface : vsw_sink_if

// *** design/vsw_sync.sv ***
`timescale 1ns/1ps
module vsw_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule : vsw_sync

// *** design/vsw_sink_chan.sv ***
`timescale 1ns/1ps
module vsw_sink_chan
    import vsw_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // register side and controls
    vsw_sink_if.chan  bus
);
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic       de_emph;
    logic       next_de_emph;
    logic       ddc_en;
    logic       next_ddc_en;
    logic       tmds_en;
    logic       next_tmds_en;
    logic [1:0] sel;
    logic [1:0] next_sel;

    // ==========================================================
    // control register and decoded outputs
    always_comb begin
        next_ctrl    = bus.wr_en ? (bus.wr_data & SINK_WR_MASK) : ctrl;
        next_de_emph = ctrl[SINK_DEEMPH_BIT];
        next_ddc_en  = ctrl[SINK_DDC_BIT];
        next_sel     = ctrl[SINK_SEL_LSB+:2];
        // drive only if enabled and, when gated, the chosen source has power
        next_tmds_en = !ctrl[SINK_OE_BIT] && (!bus.gate || bus.power[ctrl[SINK_SEL_LSB+:2]]);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl    <= REG_RESET;
            de_emph <= 1'b0;
            ddc_en  <= 1'b0;
            tmds_en <= 1'b0;
            sel     <= 2'h0;
        end else begin
            ctrl    <= next_ctrl;
            de_emph <= next_de_emph;
            ddc_en  <= next_ddc_en;
            tmds_en <= next_tmds_en;
            sel     <= next_sel;
        end
    end

    assign bus.ctrl    = ctrl;
    assign bus.de_emph = de_emph;
    assign bus.ddc_en  = ddc_en;
    assign bus.tmds_en = tmds_en;
    assign bus.sel     = sel;

    // ==========================================================
    // checks
    ctrl_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
        bus.wr_en |=> (ctrl == ($past(bus.wr_data) & SINK_WR_MASK)))
        else $error("sink control write not stored with mask");
    reserved_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
        ctrl[7:5] == 3'h0)
        else $error("sink reserved bits not zero");
    fields_follow_a: assert property (@(posedge mclk) disable iff (!rst_b)
        bus.wr_en |=> ##1 (de_emph == $past(ctrl[SINK_DEEMPH_BIT]) && ddc_en == $past(ctrl[SINK_DDC_BIT])
                           && sel == $past(ctrl[SINK_SEL_LSB+:2])))
        else $error("sink outputs do not follow control");
    tmds_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (bus.gate && !bus.power[ctrl[SINK_SEL_LSB+:2]]) |=> !tmds_en)
        else $error("sink drives from unpowered source");
endmodule : vsw_sink_chan

// *** design/vsw_regs.sv ***
`timescale 1ns/1ps
// Behaviour
// - sink control bits 7..5 are reserved, no function, default zero.
// - sink bit 4 set turns the sink's 3 dB de-emphasis on.
// - sink bit 3 set enables the sink-side DDC buffer, cleared makes it high-Z.
// - sink bit 2 cleared drives TMDS outputs, set makes them high-Z.
// - sink bits 1..0 choose source port 1 to 4 by codes 00..11.
// - each sink control register governs only its own sink.
// - status bits 3..0 show 5 V presence of sources 4..1.
// - unpowered source disables its DDC buffer; selecting sink outputs go high-Z while status bit 4 is set.
// - powered source enables its DDC buffer; selecting sink follows output enable.
// - status bit 4 set makes TMDS state depend on source power.
// - status bit 5 picks main display sink; bits 7..6 reserved zero.
// - device acknowledges slave address, sub-address and data byte.
// - one register byte per transaction; no bursts.
// - address bits 2..1 come from the two strap pins.
// - on read address, device returns one byte of the selected register.
// - sub-addresses 01, 02, 03 map to sink 1, sink 2, status.
// - every register resets to 0000 0011; status here resets to 0000 0000 (writable bits only).
// - upper five slave address bits are fixed 01011.
module vsw_regs
    import vsw_pkg::*;
(
    // system clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // serial link
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic       addr_strap_high,
    input  wire logic       addr_strap_low,
    // source power indications
    input  wire logic       source1_power_present,
    input  wire logic       source2_power_present,
    input  wire logic       source3_power_present,
    input  wire logic       source4_power_present,
    // sink 1 controls
    output logic            sink1_de_emphasis,
    output logic            sink1_ddc_buffer_enable,
    output logic            sink1_tmds_enable,
    output logic [1:0]      sink1_source_select,
    // sink 2 controls
    output logic            sink2_de_emphasis,
    output logic            sink2_ddc_buffer_enable,
    output logic            sink2_tmds_enable,
    output logic [1:0]      sink2_source_select,
    // source and display controls
    output logic [3:0]      source_ddc_buffer_enable,
    output logic            main_display_select
);
    // ==========================================================
    // start and stop detection on data edges
    logic       start_tog;
    logic       next_start_tog;
    logic       stop_tog;
    logic       next_stop_tog;

    always_comb begin
        next_start_tog = scl_i ? ~start_tog : start_tog;
        next_stop_tog  = scl_i ? ~stop_tog : stop_tog;
    end

    always_ff @(negedge sda_i or negedge rst_b) begin
        if (!rst_b) begin
            start_tog <= 1'b0;
        end else begin
            start_tog <= next_start_tog;
        end
    end

    always_ff @(posedge sda_i or negedge rst_b) begin
        if (!rst_b) begin
            stop_tog <= 1'b0;
        end else begin
            stop_tog <= next_stop_tog;
        end
    end

    // ==========================================================
    // link engine on the serial clock
    vsw_state_t state;
    vsw_state_t next_state;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [6:0] shift;
    logic [6:0] next_shift;
    logic [7:0] tx;
    logic [7:0] next_tx;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic [7:0] wr_addr_l;
    logic [7:0] next_wr_addr_l;
    logic [7:0] wr_data_l;
    logic [7:0] next_wr_data_l;
    logic       wr_tog;
    logic       next_wr_tog;
    logic       frame_tog;
    logic       next_frame_tog;
    logic       start_ack;
    logic       next_start_ack;
    logic       rw;
    logic       next_rw;
    logic       next_sda_oe;
    logic [1:0] strap_s;
    logic [7:0] rx_byte;
    logic       start_seen;
    logic       byte_done;
    logic [7:0] snap;

    vsw_sync #(.WIDTH(2)) u_strap_sync (
        .clk   (scl_i),
        .rst_b (rst_b),
        .d     ({addr_strap_high, addr_strap_low}),
        .q     (strap_s)
    );

    // start toggle is steady for a whole low phase before the next rise
    assign start_seen = start_tog ^ start_ack;
    assign rx_byte    = {shift, sda_i};
    assign byte_done  = (bit_cnt == 3'h7);

    always_comb begin
        next_state     = state;
        next_bit_cnt   = bit_cnt + 3'h1;
        next_shift     = {shift[5:0], sda_i};
        next_tx        = tx;
        next_ptr       = ptr;
        next_wr_addr_l = wr_addr_l;
        next_wr_data_l = wr_data_l;
        next_wr_tog    = wr_tog;
        next_frame_tog = frame_tog;
        next_start_ack = start_ack;
        next_rw        = rw;
        if (start_seen) begin
            next_start_ack = start_tog;
            next_frame_tog = ~frame_tog;
            next_state     = ST_ADDR;
            next_bit_cnt   = 3'h1;
        end else begin
            case (state)
                ST_ADDR: begin
                    if (byte_done) begin
                        if (rx_byte[7:1] == {ADDR_PREFIX, strap_s}) begin
                            next_rw    = rx_byte[0];
                            next_state = ST_ADDR_ACK;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    next_bit_cnt = 3'h0;
                    if (rw) begin
                        next_tx    = snap;
                        next_state = ST_READ;
                    end else begin
                        next_state = ST_SUB;
                    end
                end
                ST_SUB: begin
                    if (byte_done) begin
                        next_ptr   = rx_byte;
                        next_state = ST_SUB_ACK;
                    end
                end
                ST_SUB_ACK: begin
                    next_bit_cnt = 3'h0;
                    next_state   = ST_DATA;
                end
                ST_DATA: begin
                    if (byte_done) begin
                        next_wr_addr_l = ptr;
                        next_wr_data_l = rx_byte;
                        next_wr_tog    = ~wr_tog;
                        next_state     = ST_DATA_ACK;
                    end
                end
                ST_DATA_ACK: begin
                    next_state = ST_IDLE;
                end
                ST_READ: begin
                    next_tx = {tx[6:0], 1'b0};
                    if (byte_done) begin
                        next_state = ST_READ_ACK;
                    end
                end
                ST_READ_ACK: begin
                    next_state = ST_IDLE;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge scl_i or negedge rst_b) begin
        if (!rst_b) begin
            state     <= ST_IDLE;
            bit_cnt   <= 3'h0;
            shift     <= 7'h00;
            tx        <= 8'h00;
            ptr       <= SUB_RESET;
            wr_addr_l <= 8'h00;
            wr_data_l <= 8'h00;
            wr_tog    <= 1'b0;
            frame_tog <= 1'b0;
            start_ack <= 1'b0;
            rw        <= 1'b0;
        end else begin
            state     <= next_state;
            bit_cnt   <= next_bit_cnt;
            shift     <= next_shift;
            tx        <= next_tx;
            ptr       <= next_ptr;
            wr_addr_l <= next_wr_addr_l;
            wr_data_l <= next_wr_data_l;
            wr_tog    <= next_wr_tog;
            frame_tog <= next_frame_tog;
            start_ack <= next_start_ack;
            rw        <= next_rw;
        end
    end

    // ==========================================================
    // data line drive, changed only while the clock is low
    always_comb begin
        case (state)
            ST_ADDR_ACK, ST_SUB_ACK, ST_DATA_ACK: begin
                next_sda_oe = 1'b1;
            end
            ST_READ: begin
                next_sda_oe = ~tx[7];
            end
            default: begin
                next_sda_oe = 1'b0;
            end
        endcase
    end

    always_ff @(negedge scl_i or negedge rst_b) begin
        if (!rst_b) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= next_sda_oe;
        end
    end

    // ==========================================================
    // system side: crossings, status register, read snapshot
    logic [2:0] tog_s;
    logic [2:0] tog_d;
    logic [3:0] pwr_s;
    logic       wr_pulse;
    logic       frame_pulse;
    logic       stop_pulse;
    logic       freeze;
    logic       next_freeze;
    logic [7:0] stat_ctl;
    logic [7:0] next_stat_ctl;
    logic [7:0] next_snap;
    logic [3:0] next_src_ddc;
    logic       next_main;
    logic       next_sda_o;
    vsw_sink_if s1 ();
    vsw_sink_if s2 ();

    vsw_sync #(.WIDTH(3)) u_tog_sync (
        .clk   (mclk),
        .rst_b (rst_b),
        .d     ({stop_tog, frame_tog, wr_tog}),
        .q     (tog_s)
    );

    vsw_sync #(.WIDTH(NUM_SOURCES)) u_pwr_sync (
        .clk   (mclk),
        .rst_b (rst_b),
        .d     ({source4_power_present, source3_power_present,
                 source2_power_present, source1_power_present}),
        .q     (pwr_s)
    );

    assign wr_pulse    = tog_s[0] ^ tog_d[0];
    assign frame_pulse = tog_s[1] ^ tog_d[1];
    assign stop_pulse  = tog_s[2] ^ tog_d[2];

    assign s1.wr_en   = wr_pulse && (wr_addr_l == SUB_SINK1);
    assign s2.wr_en   = wr_pulse && (wr_addr_l == SUB_SINK2);
    assign s1.wr_data = wr_data_l;
    assign s2.wr_data = wr_data_l;
    assign s1.power   = pwr_s;
    assign s2.power   = pwr_s;
    assign s1.gate    = stat_ctl[STAT_GATE_BIT];
    assign s2.gate    = stat_ctl[STAT_GATE_BIT];

    vsw_sink_chan u_sink1 (
        .mclk  (mclk),
        .rst_b (rst_b),
        .bus   (s1)
    );

    vsw_sink_chan u_sink2 (
        .mclk  (mclk),
        .rst_b (rst_b),
        .bus   (s2)
    );

    always_comb begin
        next_freeze = freeze;
        if (frame_pulse) begin
            next_freeze = 1'b1;
        end else if (stop_pulse) begin
            next_freeze = 1'b0;
        end
        next_stat_ctl = stat_ctl;
        if (wr_pulse && (wr_addr_l == SUB_STATUS)) begin
            next_stat_ctl = wr_data_l & STAT_WR_MASK;
        end
        // snapshot held still while a frame may be reading it
        next_snap = snap;
        if (!freeze) begin
            if (ptr == SUB_SINK1) begin
                next_snap = s1.ctrl;
            end else if (ptr == SUB_SINK2) begin
                next_snap = s2.ctrl;
            end else if (ptr == SUB_STATUS) begin
                next_snap = stat_ctl | {4'h0, pwr_s};
            end else begin
                next_snap = RD_UNMAPPED;
            end
        end
        next_src_ddc = pwr_s;
        next_main    = stat_ctl[STAT_MAIN_BIT];
        next_sda_o   = 1'b0;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tog_d                    <= 3'h0;
            freeze                   <= 1'b0;
            stat_ctl                 <= STAT_RESET;
            snap                     <= 8'h00;
            source_ddc_buffer_enable <= 4'h0;
            main_display_select      <= 1'b0;
            sda_o                    <= 1'b0;
        end else begin
            tog_d                    <= tog_s;
            freeze                   <= next_freeze;
            stat_ctl                 <= next_stat_ctl;
            snap                     <= next_snap;
            source_ddc_buffer_enable <= next_src_ddc;
            main_display_select      <= next_main;
            sda_o                    <= next_sda_o;
        end
    end

    assign sink1_de_emphasis       = s1.de_emph;
    assign sink1_ddc_buffer_enable = s1.ddc_en;
    assign sink1_tmds_enable       = s1.tmds_en;
    assign sink1_source_select     = s1.sel;
    assign sink2_de_emphasis       = s2.de_emph;
    assign sink2_ddc_buffer_enable = s2.ddc_en;
    assign sink2_tmds_enable       = s2.tmds_en;
    assign sink2_source_select     = s2.sel;

    // ==========================================================
    // checks
    status_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (!freeze && ptr == SUB_STATUS) |=> (snap == ($past(stat_ctl) | {4'h0, $past(pwr_s)})))
        else $error("status snapshot wrong");
    status_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (wr_pulse && wr_addr_l == SUB_STATUS) |=> (stat_ctl == ($past(wr_data_l) & STAT_WR_MASK)))
        else $error("status write not stored with mask");
    source_ddc_a: assert property (@(posedge mclk) disable iff (!rst_b)
        1'b1 |=> (source_ddc_buffer_enable == $past(pwr_s)))
        else $error("source buffer enable not following power");
    addr_miss_a: assert property (@(posedge scl_i) disable iff (!rst_b)
        (!start_seen && state == ST_ADDR && byte_done && rx_byte[7:1] != {ADDR_PREFIX, strap_s})
        |=> (state == ST_IDLE || state == ST_ADDR))
        else $error("foreign address accepted");
    sub_ack_a: assert property (@(posedge scl_i) disable iff (!rst_b)
        (state == ST_SUB_ACK) |-> sda_oe)
        else $error("sub-address not acknowledged");
    one_byte_a: assert property (@(posedge scl_i) disable iff (!rst_b)
        (state == ST_DATA_ACK) |=> (state == ST_IDLE || state == ST_ADDR))
        else $error("write burst continued");
    read_once_a: assert property (@(posedge scl_i) disable iff (!rst_b)
        (state == ST_READ_ACK) |=> (state == ST_IDLE || state == ST_ADDR))
        else $error("read continued past one byte");
endmodule : vsw_regs

// *** tb/vsw_master.sv ***
`timescale 1ns/1ps
module vsw_master (
    // serial link
    output logic      scl,
    output logic      sda,
    input  wire logic sda_bus
);
    // ==========================================================
    // bit level, 125 ns per bit, scl idles high
    localparam realtime Q = 31.25;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic xfer(input logic b, output logic r);
        sda = b;
        #Q scl = 1'b1;
        #Q r = sda_bus;
        #Q scl = 1'b0;
        #Q;
    endtask : xfer
    task automatic xbyte(input logic [7:0] d, output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            xfer(d[i], r[i]);
        end
        xfer(1'b1, a);
        ack = ~a;
    endtask : xbyte
    task automatic start_c();
        sda = 1'b1;
        #Q scl = 1'b1;
        #Q sda = 1'b0;
        #Q scl = 1'b0;
        #Q;
    endtask : start_c
    task automatic stop_c();
        sda = 1'b0;
        #Q scl = 1'b1;
        #Q sda = 1'b1;
        #400;
    endtask : stop_c
    // ==========================================================
    // frames
    task automatic write_reg(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d,
                             output logic [2:0] ack);
        logic [7:0] r;
        start_c();
        xbyte({a, 1'b0}, r, ack[2]);
        xbyte(sub, r, ack[1]);
        xbyte(d, r, ack[0]);
        stop_c();
    endtask : write_reg
    task automatic read_reg(input logic [6:0] a, input logic [7:0] sub, output logic [7:0] d,
                            output logic [2:0] ack);
        logic [7:0] r;
        logic       k;
        start_c();
        xbyte({a, 1'b0}, r, ack[2]);
        xbyte(sub, r, ack[1]);
        stop_c();
        start_c();
        xbyte({a, 1'b1}, r, ack[0]);
        xbyte(8'hFF, d, k);
        stop_c();
    endtask : read_reg
endmodule : vsw_master

// *** tb/tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb;
    import vsw_pkg::*;
    logic        mclk, rst_b, a_hi, a_lo, bad;
    logic [3:0]  pwr;
    logic [31:0] rnd;
    logic [7:0]  rd;
    logic [2:0]  ack;
    logic [6:0]  sa;
    int          error_cnt, check_count, sink[2], stat, sub;
    wire logic   scl, sda_m, sda_o, sda_oe, s1_de, s1_ddc, s1_tm, s2_de, s2_ddc, s2_tm, msel;
    wire logic [1:0] s1_sel, s2_sel;
    wire logic [3:0] src_ddc;
    wire logic   sda_bus = sda_m & ~(sda_oe & ~sda_o);

    vsw_master m (.scl(scl), .sda(sda_m), .sda_bus(sda_bus));
    vsw_regs dut (.mclk(mclk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_strap_high(a_hi), .addr_strap_low(a_lo),
        .source1_power_present(pwr[0]), .source2_power_present(pwr[1]),
        .source3_power_present(pwr[2]), .source4_power_present(pwr[3]),
        .sink1_de_emphasis(s1_de), .sink1_ddc_buffer_enable(s1_ddc), .sink1_tmds_enable(s1_tm),
        .sink1_source_select(s1_sel), .sink2_de_emphasis(s2_de), .sink2_ddc_buffer_enable(s2_ddc),
        .sink2_tmds_enable(s2_tm), .sink2_source_select(s2_sel),
        .source_ddc_buffer_enable(src_ddc), .main_display_select(msel));

    always #20 mclk = ~mclk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic int exp_rd(input int s);
        return s == 1 ? sink[0] : s == 2 ? sink[1] : s == 3 ? (stat | pwr) : 0;
    endfunction : exp_rd
    task automatic check_out();
        int c;
        for (int s = 0; s < 2; s++) begin
            c = sink[s];
            `CHK("de", c[4], s ? s2_de : s1_de)
            `CHK("ddc", c[3], s ? s2_ddc : s1_ddc)
            `CHK("sel", c[1:0], s ? s2_sel : s1_sel)
            `CHK("tmds", ~c[2] & (~stat[4] | pwr[c[1:0]]), s ? s2_tm : s1_tm)
        end
        `CHK("src_ddc", pwr, src_ddc)
        `CHK("main", stat[5], msel)
        `CHK("sda_o", 1'b0, sda_o)
    endtask : check_out
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    initial begin
        #1000000;
        error_cnt++;
        end_sim();
    end

    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        pwr = 4'h0;
        a_hi = 1'b0;
        a_lo = 1'b1;
        rnd = 32'h4D85;
        error_cnt = 0;
        check_count = 0;
        sink = '{3, 3};
        stat = 0;
        repeat (20) @(posedge mclk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge mclk);
        check_out();
        sa = {ADDR_PREFIX, a_hi, a_lo};
        for (int s = 1; s < 4; s++) begin
            m.read_reg(sa, 8'(s), rd, ack);
            `CHK("rst_rd", 8'(exp_rd(s)), rd)
        end
        for (int n = 0; n < 20; n++) begin
            rnd = lfsr(rnd);
            sub = n % 5;
            @(posedge mclk);
            #1 pwr = rnd[3:0];
            a_hi = rnd[4];
            a_lo = rnd[5];
            sa = {ADDR_PREFIX, a_hi, a_lo};
            bad = (n % 4 == 3);
            m.write_reg(bad ? sa ^ 7'h04 : sa, 8'(sub), rnd[15:8], ack);
            `CHK("wr_ack", bad ? 3'b000 : 3'b111, ack)
            if (!bad && (sub == 1 || sub == 2)) sink[sub-1] = rnd[15:8] & 8'h1F;
            if (!bad && sub == 3) stat = rnd[15:8] & 8'h30;
            repeat (10) @(posedge mclk);
            check_out();
            m.read_reg(sa, 8'(sub), rd, ack);
            `CHK("rd_ack", 3'b111, ack)
            `CHK("rd_data", 8'(exp_rd(sub)), rd)
        end
        end_sim();
    end
endmodule : tb
